// >>> core/i3c_daa_consts.svh
// named constants for the i3c bring-up controller
`ifndef I3C_DAA_CONSTS_SVH
`define I3C_DAA_CONSTS_SVH

// functional clock and the bus bit rates it is divided down to
`define CLK_HZ          50000000
`define PP_SLOW_HZ      2000000
`define OD_SLOW_HZ      400000
`define PP_FAST_HZ      10000000
`define I2C_HZ          100000
// half-bit divider value: half period rounded up to whole cycles, minus one
`define HALF_DIV(hz)    ((`CLK_HZ + 2 * (hz) - 1) / (2 * (hz)) - 1)

// register byte offsets (8-bit decode)
`define ADDR_CTRL       8'h00
`define ADDR_CFG        8'h04
`define ADDR_STATUS     8'h08
`define ADDR_INT_STS    8'h0c
`define ADDR_INT_MSK    8'h10
`define ADDR_IBI_REG    8'h14
`define ADDR_IBI_ADDR   8'h18
`define ADDR_DEV_BASE   3'h2

// control register bits
`define CTRL_START      0
`define CTRL_LEGACY     1
`define CTRL_IBI_EN     2

// master_configuration fields
`define CFG_PPS_MSB     3
`define CFG_PPS_LSB     0
`define CFG_PPF_MSB     7
`define CFG_PPF_LSB     4
`define CFG_OD_MSB      15
`define CFG_OD_LSB      8
`define CFG_I2C_MSB     23
`define CFG_I2C_LSB     16

// interrupt status bits
`define INT_W           3
`define INT_DONE        0
`define INT_IBI_OK      1
`define INT_IBI_NAK     2

// ibi registration register fields
`define IBIR_DA_MSB     14
`define IBIR_DA_LSB     8
`define DA_BASE_RESET   7'h08

// bus protocol values
`define BCAST_ADDR      7'h7e
`define CCC_ENEC        8'h00
`define CCC_DISEC       8'h01
`define CCC_RSTDAA      8'h06
`define CCC_ENTDAA      8'h07
`define EVT_MASK        8'h0b
`define BCR_IBI_BIT     1
`define DEV_MAX         3'h4
`define ID_LAST         6'h3f
`define BYTE_LAST       6'h07
`define TBIT_LAST       6'h08

`endif

// >>> core/i3c_daa_pkg.sv
// types for the i3c bring-up controller
package i3c_daa_pkg;
	// broadcast bring-up sequence
	typedef enum logic [2:0] {SQ_IDLE, SQ_RST, SQ_DIS, SQ_DAA, SQ_EN} seq_t;
	// bit-level frame engine
	typedef enum logic [3:0] {
		B_IDLE, B_START, B_ADDR, B_AACK, B_CCC, B_DEF, B_SR, B_RADDR,
		B_RACK, B_ID, B_DA, B_DACK, B_STOP, B_IBI_ACK
	} bit_state_t;
endpackage : i3c_daa_pkg

// >>> core/i3c_master_daa_ibi.sv
// i3c bus controller: rate setup, broadcast bring-up, entdaa capture, ibi intake
// Functional notes
// - half-bit dividers are integer multiples of clock
// - slow push-pull and open-drain rates before assignment
// - faster push-pull rate allowed after assignment
// - push-pull divider field is four bits
// - legacy, push-pull, open-drain rates all configured
// - sequence opens with broadcast address reset
// - broadcast event disable before assignment
// - built-in entdaa assigns dynamic addresses
// - store pid, bcr, dcr per device
// - broadcast event enable after assignment
// - target address in header means ibi
// - assignment never relies on static addresses
`timescale 1ns/100ps
`default_nettype none
`include "i3c_daa_consts.svh"
module i3c_master_daa_ibi (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	output logic             scl_o,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe,
	output logic             irq
);
	// bus slave state
	logic        wr_pend_r, hreadyout_r, hresp_r;
	logic [7:0]  wr_addr_r;
	logic [31:0] hrdata_r, rd_data;
	// software registers
	logic        legacy_r, ibi_en_r;
	logic [23:0] cfg_r;
	logic [`INT_W-1:0] int_sts_r, int_msk_r, int_ev;
	logic [3:0]  ibi_reg_r;
	logic [6:0]  da_base_r, ibi_addr_r;
	logic        irq_r;
	// sequencer and engine
	i3c_daa_pkg::seq_t       seq_r;
	i3c_daa_pkg::bit_state_t bst_r;
	logic        go_r, daa_done_r, done_ev_r, frame_done_r, pend_r, ibi_r;
	logic        ibi_ok_r, ibi_nak_r, half_r, lost_r, lost_now, ibi_hit;
	logic [5:0]  cnt_r;
	logic [8:0]  tx_r;
	logic [7:0]  hdr_r, ccc_sel;
	logic [63:0] id_r;
	logic [6:0]  da_cur;
	logic [2:0]  dev_cnt_r;
	logic        scl_o_r, sda_o_r, sda_oe_r;
	logic [47:0] dev_pid_r [0:3];
	logic [7:0]  dev_bcr_r [0:3];
	logic [7:0]  dev_dcr_r [0:3];
	// rate enables
	logic        pp_tick, od_tick, i2c_tick, tick;
	logic [3:0]  pp_div;
	logic        ap, wr_ok, wr_ctrl, wr_cfg, wr_sts, wr_msk, wr_ibir, start_req;

	// open-drain drives only low; push-pull drives both levels
	function automatic logic [1:0] drv(input logic b, input logic pp);
		drv = pp ? {1'b1, b} : {~b, 1'b0};
	endfunction : drv

	// ahb-lite address phase; only whole-word writes are taken
	assign ap        = hsel & htrans[1] & hready;
	assign wr_ok     = wr_pend_r;
	assign wr_ctrl   = wr_ok && (wr_addr_r == `ADDR_CTRL);
	assign wr_cfg    = wr_ok && (wr_addr_r == `ADDR_CFG);
	assign wr_sts    = wr_ok && (wr_addr_r == `ADDR_INT_STS);
	assign wr_msk    = wr_ok && (wr_addr_r == `ADDR_INT_MSK);
	assign wr_ibir   = wr_ok && (wr_addr_r == `ADDR_IBI_REG);
	assign start_req = wr_ctrl & hwdata[`CTRL_START];

	// zero-wait slave; read data is sampled in the address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r   <= 1'b0;
			wr_addr_r   <= 8'h00;
			hrdata_r    <= 32'h0000_0000;
			hreadyout_r <= 1'b1;
			hresp_r     <= 1'b0;
		end else begin
			wr_pend_r   <= ap & hwrite & (hsize == 3'h2);
			hreadyout_r <= 1'b1;
			hresp_r     <= 1'b0;
			if (ap)
				wr_addr_r <= haddr[7:0];
			if (ap & ~hwrite)
				hrdata_r <= rd_data;
		end
	end

	// read mux; unmapped offsets read zero
	always_comb begin
		rd_data = 32'h0000_0000;
		unique case (haddr[7:0])
			`ADDR_CTRL:     rd_data = {29'h0, ibi_en_r, legacy_r, 1'b0};
			`ADDR_CFG:      rd_data = {8'h00, cfg_r};
			`ADDR_STATUS:   rd_data = {27'h0, dev_cnt_r,
			                           daa_done_r, (seq_r != i3c_daa_pkg::SQ_IDLE)};
			`ADDR_INT_STS:  rd_data = {29'h0, int_sts_r};
			`ADDR_INT_MSK:  rd_data = {29'h0, int_msk_r};
			`ADDR_IBI_REG:  rd_data = {17'h0, da_base_r, 4'h0, ibi_reg_r};
			`ADDR_IBI_ADDR: rd_data = {25'h0, ibi_addr_r};
			default: begin
				// device table: 0x40 + 8*slot, word 0 pid low, word 1 bcr/dcr/pid high
				if (haddr[7:5] == `ADDR_DEV_BASE)
					rd_data = haddr[2] ? {dev_bcr_r[haddr[4:3]], dev_dcr_r[haddr[4:3]],
					                      dev_pid_r[haddr[4:3]][47:32]}
					                   : dev_pid_r[haddr[4:3]][31:0];
			end
		endcase
	end

	// software-written control; slow rates are the reset values
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			legacy_r  <= 1'b0;
			ibi_en_r  <= 1'b0;
			int_msk_r <= '0;
			ibi_reg_r <= 4'h0;
			da_base_r <= `DA_BASE_RESET;
			cfg_r[`CFG_PPS_MSB:`CFG_PPS_LSB] <= 4'(`HALF_DIV(`PP_SLOW_HZ));
			cfg_r[`CFG_PPF_MSB:`CFG_PPF_LSB] <= 4'(`HALF_DIV(`PP_FAST_HZ));
			cfg_r[`CFG_OD_MSB:`CFG_OD_LSB]   <= 8'(`HALF_DIV(`OD_SLOW_HZ));
			cfg_r[`CFG_I2C_MSB:`CFG_I2C_LSB] <= 8'(`HALF_DIV(`I2C_HZ));
		end else begin
			if (wr_ctrl) begin
				legacy_r <= hwdata[`CTRL_LEGACY];
				ibi_en_r <= hwdata[`CTRL_IBI_EN];
			end
			if (wr_cfg)
				cfg_r <= hwdata[23:0];
			if (wr_msk)
				int_msk_r <= hwdata[`INT_W-1:0];
			if (wr_ibir) begin
				ibi_reg_r <= hwdata[3:0];
				da_base_r <= hwdata[`IBIR_DA_MSB:`IBIR_DA_LSB];
			end
		end
	end

	// sticky events; a new event wins over a write-one clear
	assign int_ev = {ibi_nak_r, ibi_ok_r, done_ev_r};
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			int_sts_r <= '0;
			irq_r     <= 1'b0;
		end else begin
			int_sts_r <= (int_sts_r & ~(wr_sts ? hwdata[`INT_W-1:0] : '0)) | int_ev;
			irq_r     <= |(int_sts_r & int_msk_r);
		end
	end

	// slow push-pull until final enable done
	assign pp_div = daa_done_r ? cfg_r[`CFG_PPF_MSB:`CFG_PPF_LSB]
	                           : cfg_r[`CFG_PPS_MSB:`CFG_PPS_LSB];

	rate_tick #(.W(4)) u_pp  (.hclk(hclk), .hresetn(hresetn), .div(pp_div), .tick(pp_tick));
	rate_tick #(.W(8)) u_od  (.hclk(hclk), .hresetn(hresetn),
	                          .div(cfg_r[`CFG_OD_MSB:`CFG_OD_LSB]), .tick(od_tick));
	rate_tick #(.W(8)) u_i2c (.hclk(hclk), .hresetn(hresetn),
	                          .div(cfg_r[`CFG_I2C_MSB:`CFG_I2C_LSB]), .tick(i2c_tick));

	// push-pull only for ccc payload; open-drain phases slow to legacy rate if asked
	assign tick = (bst_r == i3c_daa_pkg::B_CCC || bst_r == i3c_daa_pkg::B_DEF) ? pp_tick
	            : (legacy_r ? i2c_tick : od_tick);

	// broadcast command for the current step
	always_comb begin
		unique case (seq_r)
			i3c_daa_pkg::SQ_DIS: ccc_sel = `CCC_DISEC;
			i3c_daa_pkg::SQ_DAA: ccc_sel = `CCC_ENTDAA;
			i3c_daa_pkg::SQ_EN:  ccc_sel = `CCC_ENEC;
			default:             ccc_sel = `CCC_RSTDAA;
		endcase
	end

	always_comb begin
		ibi_hit = 1'b0;
		for (int i = 0; i < 4; i++) begin
			if (3'(i) < dev_cnt_r && ibi_reg_r[i] && dev_bcr_r[i][`BCR_IBI_BIT]
			    && hdr_r[6:0] == 7'(da_base_r + 7'(i)))
				ibi_hit = 1'b1;
		end
		ibi_hit = ibi_hit & ibi_en_r;
	end

	assign da_cur   = 7'(da_base_r + {4'h0, dev_cnt_r});
	assign lost_now = lost_r | (sda_i != tx_r[8]);

	// bring-up order: reset, disable, assign, enable
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			seq_r      <= i3c_daa_pkg::SQ_IDLE;
			go_r       <= 1'b0;
			daa_done_r <= 1'b0;
			done_ev_r  <= 1'b0;
		end else begin
			go_r      <= 1'b0;
			done_ev_r <= 1'b0;
			unique case (seq_r)
				i3c_daa_pkg::SQ_IDLE: if (start_req) begin
					seq_r      <= i3c_daa_pkg::SQ_RST;
					go_r       <= 1'b1;
					daa_done_r <= 1'b0;
				end
				i3c_daa_pkg::SQ_RST: if (frame_done_r) begin
					seq_r <= i3c_daa_pkg::SQ_DIS;
					go_r  <= 1'b1;
				end
				i3c_daa_pkg::SQ_DIS: if (frame_done_r) begin
					seq_r <= i3c_daa_pkg::SQ_DAA;
					go_r  <= 1'b1;
				end
				i3c_daa_pkg::SQ_DAA: if (frame_done_r) begin
					seq_r <= i3c_daa_pkg::SQ_EN;
					go_r  <= 1'b1;
				end
				i3c_daa_pkg::SQ_EN: if (frame_done_r) begin
					seq_r      <= i3c_daa_pkg::SQ_IDLE;
					daa_done_r <= 1'b1;
					done_ev_r  <= 1'b1;
				end
			endcase
		end
	end

	// frame engine: scl low half then high half, sampling at the high half's end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bst_r        <= i3c_daa_pkg::B_IDLE;
			half_r       <= 1'b0;
			cnt_r        <= 6'h00;
			tx_r         <= 9'h1ff;
			hdr_r        <= 8'h00;
			id_r         <= 64'h0;
			lost_r       <= 1'b0;
			ibi_r        <= 1'b0;
			pend_r       <= 1'b0;
			frame_done_r <= 1'b0;
			ibi_ok_r     <= 1'b0;
			ibi_nak_r    <= 1'b0;
			ibi_addr_r   <= 7'h00;
			dev_cnt_r    <= 3'h0;
			scl_o_r      <= 1'b1;
			sda_o_r      <= 1'b0;
			sda_oe_r     <= 1'b0;
			for (int i = 0; i < 4; i++) begin
				dev_pid_r[i] <= 48'h0;
				dev_bcr_r[i] <= 8'h00;
				dev_dcr_r[i] <= 8'h00;
			end
		end else begin
			frame_done_r <= 1'b0;
			ibi_ok_r     <= 1'b0;
			ibi_nak_r    <= 1'b0;
			if (go_r)
				pend_r <= 1'b1;
			if (go_r && seq_r == i3c_daa_pkg::SQ_RST)
				dev_cnt_r <= 3'h0;
			if (bst_r == i3c_daa_pkg::B_IDLE) begin
				// a target start is always clocked out
				if (!sda_i || ((pend_r | go_r) && tick)) begin
					bst_r                <= i3c_daa_pkg::B_START;
					half_r               <= 1'b1;
					{sda_oe_r, sda_o_r}  <= drv(1'b0, 1'b0);
				end
			end else if (bst_r == i3c_daa_pkg::B_START) begin
				if (tick) begin
					// broadcast header, no static address used
					scl_o_r             <= 1'b0;
					half_r              <= 1'b0;
					cnt_r               <= 6'h00;
					lost_r              <= 1'b0;
					tx_r                <= {`BCAST_ADDR, 1'b0, 1'b1};
					{sda_oe_r, sda_o_r} <= drv(1'(`BCAST_ADDR >> 6), 1'b0);
					bst_r               <= i3c_daa_pkg::B_ADDR;
				end
			end else if (tick && !half_r) begin
				scl_o_r <= 1'b1;
				half_r  <= 1'b1;
				if (bst_r == i3c_daa_pkg::B_STOP)
					{sda_oe_r, sda_o_r} <= drv(1'b0, 1'b0);
			end else if (tick) begin
				half_r  <= 1'b0;
				scl_o_r <= 1'b0;
				cnt_r   <= cnt_r + 6'h01;
				tx_r    <= {tx_r[7:0], 1'b1};
				unique case (bst_r)
					i3c_daa_pkg::B_ADDR: begin
						hdr_r  <= {hdr_r[6:0], sda_i};
						lost_r <= lost_now;
						if (cnt_r != `BYTE_LAST)
							{sda_oe_r, sda_o_r} <= drv(tx_r[7] | lost_now, 1'b0);
						else if (lost_now) begin
							// header lost to a target address
							ibi_r               <= 1'b1;
							ibi_addr_r          <= hdr_r[6:0];
							ibi_ok_r            <= ibi_hit;
							ibi_nak_r           <= ~ibi_hit;
							{sda_oe_r, sda_o_r} <= drv(~ibi_hit, 1'b0);
							bst_r               <= i3c_daa_pkg::B_IBI_ACK;
						end else begin
							{sda_oe_r, sda_o_r} <= drv(1'b1, 1'b0);
							bst_r               <= i3c_daa_pkg::B_AACK;
						end
					end
					i3c_daa_pkg::B_AACK: if (sda_i) begin
						{sda_oe_r, sda_o_r} <= drv(1'b0, 1'b0);
						bst_r               <= i3c_daa_pkg::B_STOP;
					end else begin
						cnt_r               <= 6'h00;
						tx_r                <= {ccc_sel, ~^ccc_sel};
						{sda_oe_r, sda_o_r} <= drv(ccc_sel[7], 1'b1);
						bst_r               <= i3c_daa_pkg::B_CCC;
					end
					i3c_daa_pkg::B_CCC, i3c_daa_pkg::B_DEF: begin
						if (cnt_r != `TBIT_LAST)
							{sda_oe_r, sda_o_r} <= drv(tx_r[7], 1'b1);
						else if (bst_r == i3c_daa_pkg::B_CCC && (seq_r == i3c_daa_pkg::SQ_DIS
						         || seq_r == i3c_daa_pkg::SQ_EN)) begin
							cnt_r               <= 6'h00;
							tx_r                <= {`EVT_MASK, ~^`EVT_MASK};
							{sda_oe_r, sda_o_r} <= drv(1'(`EVT_MASK >> 7), 1'b1);
							bst_r               <= i3c_daa_pkg::B_DEF;
						end else if (bst_r == i3c_daa_pkg::B_CCC && seq_r == i3c_daa_pkg::SQ_DAA) begin
							cnt_r               <= 6'h00;
							{sda_oe_r, sda_o_r} <= drv(1'b1, 1'b0);
							bst_r               <= i3c_daa_pkg::B_SR;
						end else begin
							{sda_oe_r, sda_o_r} <= drv(1'b0, 1'b0);
							bst_r               <= i3c_daa_pkg::B_STOP;
						end
					end
					i3c_daa_pkg::B_SR: if (cnt_r == 6'h00) begin
						// sda falls while scl stays high
						scl_o_r             <= 1'b1;
						half_r              <= 1'b1;
						{sda_oe_r, sda_o_r} <= drv(1'b0, 1'b0);
					end else begin
						cnt_r               <= 6'h00;
						tx_r                <= {`BCAST_ADDR, 1'b1, 1'b1};
						{sda_oe_r, sda_o_r} <= drv(1'b1, 1'b0);
						bst_r               <= i3c_daa_pkg::B_RADDR;
					end
					i3c_daa_pkg::B_RADDR, i3c_daa_pkg::B_DA: begin
						if (cnt_r != `BYTE_LAST)
							{sda_oe_r, sda_o_r} <= drv(tx_r[7], 1'b0);
						else begin
							{sda_oe_r, sda_o_r} <= drv(1'b1, 1'b0);
							bst_r <= (bst_r == i3c_daa_pkg::B_DA) ? i3c_daa_pkg::B_DACK
							                                      : i3c_daa_pkg::B_RACK;
						end
					end
					i3c_daa_pkg::B_RACK: if (sda_i || dev_cnt_r == `DEV_MAX) begin
						// no target left (or table full): assignment ends
						{sda_oe_r, sda_o_r} <= drv(1'b0, 1'b0);
						bst_r               <= i3c_daa_pkg::B_STOP;
					end else begin
						cnt_r <= 6'h00;
						bst_r <= i3c_daa_pkg::B_ID;
					end
					i3c_daa_pkg::B_ID: begin
						id_r <= {id_r[62:0], sda_i};
						if (cnt_r == `ID_LAST) begin
							// pid, bcr, dcr kept per slot
							dev_pid_r[dev_cnt_r[1:0]] <= id_r[62:15];
							dev_bcr_r[dev_cnt_r[1:0]] <= id_r[14:7];
							dev_dcr_r[dev_cnt_r[1:0]] <= {id_r[6:0], sda_i};
							cnt_r                     <= 6'h00;
							tx_r                      <= {da_cur, ~^da_cur, 1'b1};
							{sda_oe_r, sda_o_r}       <= drv(da_cur[6], 1'b0);
							bst_r                     <= i3c_daa_pkg::B_DA;
						end
					end
					i3c_daa_pkg::B_DACK: begin
						// acked address counts; a nack retries the same slot
						if (!sda_i)
							dev_cnt_r <= dev_cnt_r + 3'h1;
						cnt_r               <= 6'h00;
						{sda_oe_r, sda_o_r} <= drv(1'b1, 1'b0);
						bst_r               <= i3c_daa_pkg::B_SR;
					end
					i3c_daa_pkg::B_IBI_ACK: begin
						{sda_oe_r, sda_o_r} <= drv(1'b0, 1'b0);
						bst_r               <= i3c_daa_pkg::B_STOP;
					end
					i3c_daa_pkg::B_STOP: begin
						// stop; a broadcast cut by an ibi stays pending and reruns
						scl_o_r             <= 1'b1;
						{sda_oe_r, sda_o_r} <= drv(1'b1, 1'b0);
						bst_r               <= i3c_daa_pkg::B_IDLE;
						ibi_r               <= 1'b0;
						if (!ibi_r) begin
							frame_done_r <= 1'b1;
							pend_r       <= 1'b0;
						end
					end
					default: bst_r <= i3c_daa_pkg::B_IDLE;
				endcase
			end
		end
	end

	assign hrdata    = hrdata_r;
	assign hreadyout = hreadyout_r;
	assign hresp     = hresp_r;
	assign scl_o     = scl_o_r;
	assign sda_o     = sda_o_r;
	assign sda_oe    = sda_oe_r;
	assign irq       = irq_r;
endmodule : i3c_master_daa_ibi
`default_nettype wire

// >>> core/rate_tick.sv
// free-running divider giving a one-cycle enable every div+1 clocks
`timescale 1ns/100ps
`default_nettype none
module rate_tick #(
	parameter int W = 8
) (
	input  wire logic         hclk,
	input  wire logic         hresetn,
	input  wire logic [W-1:0] div,
	output logic              tick
);
	logic [W-1:0] cnt_r;
	logic         tick_r;

	// a lowered divider takes effect at once through the >= compare
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_r  <= '0;
			tick_r <= 1'b0;
		end else if (cnt_r >= div) begin
			cnt_r  <= '0;
			tick_r <= 1'b1;
		end else begin
			cnt_r  <= cnt_r + 1'b1;
			tick_r <= 1'b0;
		end
	end

	assign tick = tick_r;
endmodule : rate_tick
`default_nettype wire

// >>> dv/i3c_master_daa_ibi_assertions.sv
// port checker for the i3c bring-up controller
`timescale 1ns/100ps
`default_nettype none
`include "i3c_daa_consts.svh"
module i3c_master_daa_ibi_assertions (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [2:0]  hsize,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        scl_o,
	input wire logic        sda_i,
	input wire logic        sda_o,
	input wire logic        sda_oe,
	input wire logic        irq
);
	logic       rd_req;
	logic       wv_r;
	logic [7:0] wa_r;
	logic [2:0] msk_r;
	logic [3:0] fast_r;
	logic [7:0] hi_cnt_r;
	assign rd_req = hsel & htrans[1] & hready & ~hwrite;
	// word writes seen in address phase, committed in data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wv_r <= 1'b0;
			wa_r <= 8'h00;
		end else begin
			wv_r <= hsel & htrans[1] & hready & hwrite & (hsize == 3'h2);
			wa_r <= haddr[7:0];
		end
	end
	// shadow of mask and fast divider; assumes fast stays the quickest rate
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			msk_r  <= 3'h0;
			fast_r <= 4'h2;
		end else if (wv_r && wa_r == `ADDR_INT_MSK) begin
			msk_r <= hwdata[2:0];
		end else if (wv_r && wa_r == `ADDR_CFG) begin
			fast_r <= hwdata[7:4];
		end
	end
	// length of the current scl high run, saturating so idle is visible
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) hi_cnt_r <= 8'h00;
		else if (!scl_o) hi_cnt_r <= 8'h00;
		else if (hi_cnt_r != 8'hff) hi_cnt_r <= hi_cnt_r + 8'h01;
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	ready_high_a: assert property (hreadyout)
		else $error("hreadyout low");
	okay_resp_a: assert property (!hresp)
		else $error("hresp not okay");
	reset_idle_a: assert property ($rose(hresetn) |-> scl_o && !sda_oe && !irq)
		else $error("bus not idle after reset");
	unmapped_zero_a: assert property (rd_req && haddr[7:5] == 3'h1 |=> hrdata == 32'h0)
		else $error("unmapped read not zero");
	rdata_hold_a: assert property (!rd_req |=> $stable(hrdata))
		else $error("read data moved without a read");
	irq_masked_a: assert property (msk_r == 3'h0 ##1 msk_r == 3'h0 |-> !irq)
		else $error("irq with all sources masked");
	start_kick_a: assert property (wv_r && wa_r == `ADDR_CTRL && hwdata[0]
		&& hi_cnt_r == 8'hff && !sda_oe |-> ##[1:600] sda_oe)
		else $error("start write did not open a frame");
	scl_high_min_a: assert property ($fell(scl_o) |-> hi_cnt_r > {4'h0, fast_r})
		else $error("scl high half shorter than divider");
	start_cov: cover property ($rose(sda_oe));
	irq_cov: cover property ($rose(irq));
	ibi_addr_cov: cover property (rd_req && haddr[7:0] == `ADDR_IBI_ADDR);
endmodule : i3c_master_daa_ibi_assertions
bind i3c_master_daa_ibi i3c_master_daa_ibi_assertions u_chk (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .scl_o(scl_o), .sda_i(sda_i), .sda_o(sda_o),
	.sda_oe(sda_oe), .irq(irq));
`default_nettype wire

// >>> dv/i3c_target_model.sv
// behavioural i3c target: header ack, ccc capture, entdaa answer, ibi request
`timescale 1ns/100ps
`default_nettype none
module i3c_target_model #(
	parameter logic [47:0] PID = 48'h0a5b3c1d2e4f, // arbitrary id value
	parameter logic [7:0]  BCR = 8'h06,
	parameter logic [7:0]  DCR = 8'h3c
) (
	input  wire logic        hclk,
	input  wire logic        scl,
	input  wire logic        sda,
	input  wire logic        ibi_req,
	output logic             pull_low,
	output logic [6:0]       dyn_addr,
	output logic             has_da,
	output logic             ev_en,
	output logic [31:0]      ccc_log,
	output logic             ibi_ack,
	output logic             ibi_done
);
	logic [63:0] id = {PID, BCR, DCR};
	logic [7:0]  sh = 8'h00;
	logic        ps = 1'b1, pd = 1'b1, hdr = 1'b0, daa = 1'b0, act = 1'b0, ibi = 1'b0;
	logic        seen = 1'b0;
	int          cnt = -1, n;
	// power-up state
	initial begin
		pull_low = 1'b0;
		dyn_addr = 7'h00;
		has_da   = 1'b0;
		ev_en    = 1'b1;
		ccc_log  = 32'h0;
		ibi_ack  = 1'b0;
		ibi_done = 1'b0;
	end
	// frame tracking on sampled levels; drive changes only on hclk edges
	always @(posedge hclk) begin
		n = cnt + 1;
		if (ps && scl && pd && !sda) begin
			cnt = 0;
			ibi = pull_low;
		end else if (ps && scl && !pd && sda && cnt >= 0) begin
			cnt = -1;
			daa = 1'b0;
			act = 1'b0;
			ibi_done <= ibi;
			ibi = 1'b0;
		end else if (!ps && scl && cnt >= 0) begin
			cnt = n;
			sh = {sh[6:0], sda};
			if (cnt == 8) begin
				// broadcast acked without static address, unassigned only join
				hdr = (sh == 8'hfc);
				act = (sh == 8'hfd) && daa && !has_da;
			end
			if (cnt == 9 && ibi) ibi_ack <= !sda;
			if (cnt == 17 && hdr && !daa) begin
				ccc_log <= {ccc_log[23:0], sh};
				if (sh == 8'h06) has_da <= 1'b0;
				if (sh == 8'h01) ev_en <= 1'b0;
				if (sh == 8'h00) ev_en <= 1'b1;
				if (sh == 8'h07) daa = 1'b1;
			end
			if (cnt == 81 && act) dyn_addr <= sh[7:1];
			if (cnt == 82 && act) has_da <= 1'b1;
		end else if (ps && !scl && cnt >= 0) begin
			if (ibi) pull_low <= (n <= 7) && !dyn_addr[7 - n];
			else if (n == 9) pull_low <= hdr || act;
			// provisional id, bcr, dcr sent msb first
			else if (act && n >= 10 && n <= 73) pull_low <= !id[73 - n];
			else pull_low <= act && n == 82;
		end
		// one ibi per request, only from an idle bus with events on
		if (!ibi_req) begin
			seen = 1'b0;
			ibi_done <= 1'b0;
		end else if (!seen && cnt < 0 && scl && sda && ev_en && has_da) begin
			seen = 1'b1;
			pull_low <= 1'b1;
		end
		ps = scl;
		pd = sda;
	end
endmodule : i3c_target_model
`default_nettype wire

// >>> dv/testbench.sv
// testbench: register map, bring-up sequence, entdaa capture, ibi intake
`timescale 1ns/100ps
`default_nettype none
`include "i3c_daa_consts.svh"
module testbench;
	logic        hclk, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, ibi_req = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, q, hrdata, ccc_log;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h2;
	logic        hreadyout, hresp, scl_o, sda_o, sda_oe, irq, meas = 1'b0;
	logic        pull_low, has_da, ev_en, ibi_ack, ibi_done;
	logic [6:0]  dyn_addr;
	wire logic   hready, sda_w;
	int          bad_count = 0, n_checks = 0, hi = 0, min_hi = 255, k, i;
	// pulled-up sda: any low driver wins
	assign sda_w = ~((sda_oe & ~sda_o) | pull_low);
	assign hready = hreadyout;
	i3c_master_daa_ibi u_i3c_master_daa_ibi (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.scl_o(scl_o), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq));
	i3c_target_model u_i3c_target_model (.hclk(hclk), .scl(scl_o), .sda(sda_w),
		.ibi_req(ibi_req), .pull_low(pull_low), .dyn_addr(dyn_addr), .has_da(has_da),
		.ev_en(ev_en), .ccc_log(ccc_log), .ibi_ack(ibi_ack), .ibi_done(ibi_done));
	// 50 MHz clock
	initial begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end
	// shortest scl high run while the sequence runs
	always @(posedge hclk) begin
		if (scl_o === 1'b1) hi = hi + 1;
		else begin
			if (meas && hi > 0 && hi < min_hi) min_hi = hi;
			hi = 0;
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// one single transfer; extra idle cycle lets a write land before a read
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [2:0] sz);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		hsize <= sz;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		q = hrdata;
		@(posedge hclk);
	endtask : xfer
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d, 3'h2);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0, 3'h2);
		chk(q, e);
	endtask : rd
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : wrap_up
	// watchdog well beyond the expected run
	initial begin
		repeat (60000) @(posedge hclk);
		bad_count++;
		wrap_up();
	end
	initial begin
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(`ADDR_CFG, 32'h00f93e2c);
		rd(`ADDR_IBI_REG, 32'h00000800);
		rd(`ADDR_STATUS, 32'h0);
		wr(8'h24, 32'hffffffff);
		rd(8'h24, 32'h0);
		xfer(1'b1, `ADDR_INT_MSK, 32'h7, 3'h0);
		rd(`ADDR_INT_MSK, 32'h0);
		wr(`ADDR_CFG, 32'h00090713);
		rd(`ADDR_CFG, 32'h00090713);
		wr(`ADDR_INT_MSK, 32'h1);
		repeat (300) @(posedge hclk);
		meas = 1'b1;
		wr(`ADDR_CTRL, 32'h1);
		for (i = 0; i < 20000 && irq !== 1'b1; i++) @(posedge hclk);
		meas = 1'b0;
		chk({31'h0, irq}, 32'h1);
		chk({31'h0, min_hi >= 4}, 32'h1);
		rd(`ADDR_INT_STS, 32'h1);
		rd(`ADDR_STATUS, 32'h6);
		rd(8'h40, 32'h3c1d2e4f);
		rd(8'h44, 32'h063c0a5b);
		chk(ccc_log, 32'h06010700);
		chk({25'h0, dyn_addr}, {25'h0, `DA_BASE_RESET});
		wr(`ADDR_INT_STS, 32'h1);
		rd(`ADDR_INT_STS, 32'h0);
		chk({31'h0, irq}, 32'h0);
		wr(`ADDR_INT_MSK, 32'h6);
		// declined unregistered, declined with intake off at legacy rate, then accepted
		for (k = 0; k < 3; k++) begin
			wr(`ADDR_CTRL, (k == 1) ? 32'h2 : 32'h4);
			rd(`ADDR_CTRL, (k == 1) ? 32'h2 : 32'h4);
			wr(`ADDR_IBI_REG, (k == 0) ? 32'h800 : 32'h801);
			min_hi = 255;
			meas = 1'b1;
			ibi_req <= 1'b1;
			for (i = 0; i < 20000 && ibi_done !== 1'b1; i++) @(posedge hclk);
			meas = 1'b0;
			ibi_req <= 1'b0;
			// open-drain high half: od divider 7 -> 8 clocks, legacy divider 9 -> 10 clocks
			chk({31'h0, min_hi >= ((k == 1) ? 10 : 8)}, 32'h1);
			chk({31'h0, ibi_done}, 32'h1);
			chk({31'h0, ibi_ack}, (k == 2) ? 32'h1 : 32'h0);
			rd(`ADDR_IBI_ADDR, 32'h8);
			rd(`ADDR_INT_STS, (k == 2) ? 32'h2 : 32'h4);
			chk({31'h0, irq}, 32'h1);
			wr(`ADDR_INT_STS, 32'h6);
		end
		wrap_up();
	end
endmodule : testbench
`default_nettype wire
